// [src/touch_pkg.sv]
`default_nettype none
package touch_pkg;
    localparam int NUM_MODULES     = 5;
    localparam int KEYS_PER_MODULE = 4;
    localparam int NUM_KEYS        = NUM_MODULES * KEYS_PER_MODULE;
    localparam int CNT_W           = 16;
    localparam int SLOT8_W         = 8;
    localparam int SLOT5_W         = 5;
    localparam int ADDR_W          = 8;
    localparam int DATA_W          = 8;

    // Register map
    localparam logic [7:0] CTRL0_ADDR      = 8'h00;
    localparam logic [7:0] REF_CNT_LO_ADDR = 8'h01;
    localparam logic [7:0] REF_CNT_HI_ADDR = 8'h02;
    localparam logic [7:0] MOD_BASE_ADDR   = 8'h10;
    localparam int         MOD_STRIDE_LOG2 = 3;
    localparam logic [2:0] MOD_CTL0_OFS    = 3'h0;
    localparam logic [2:0] MOD_CTL1_OFS    = 3'h1;
    localparam logic [2:0] MOD_PRELOAD_OFS = 3'h2;
    localparam logic [2:0] MOD_CNT_LO_OFS  = 3'h3;
    localparam logic [2:0] MOD_CNT_HI_OFS  = 3'h4;

    // touch_control_0 fields
    localparam int START_BIT     = 0;
    localparam int COMMON_BIT    = 1;
    localparam int SENSE_OVF_BIT = 2;
    localparam int REF_OVF_BIT   = 3;
    localparam int SLOT_FLAG_BIT = 4;

    // module_control_0 / module_control_1 fields
    localparam int KEY_SEL_LSB      = 6;
    localparam int SLOT_CLK_SEL_BIT = 7;
    localparam int REF_EN_BIT       = 5;
    localparam int KEY_EN_BIT       = 4;

    // Reset values
    localparam logic [7:0] CTRL0_RST   = 8'h00;
    localparam logic [7:0] MOD_CTL_RST = 8'h00;
    localparam logic [7:0] PRELOAD_RST = 8'h00;

    // System clock divider for the slot clock
    localparam int         SYS_DIV      = 4;
    localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN  = 2'b01,
        SCAN_DONE = 2'b11
    } scan_state_t;
endpackage
`default_nettype wire

// [src/sync2.sv]
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // First stage feeds only the second
    always_comb begin
        s_next        = s_reg;
        s_next.meta   = d_i;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.stable;
endmodule
`default_nettype wire

// [src/key_module_counter.sv]
`default_nettype none
module key_module_counter
    import touch_pkg::*;
#(
    parameter bit HAS_REF_COUNTER = 1'b0
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               run_i,
    input  wire logic               clear_i,
    input  wire logic               load_i,
    input  wire logic               slot_clk_sel_i,
    input  wire logic               div_tick_i,
    input  wire logic               sense_lvl_i,
    input  wire logic               ref_lvl_i,
    input  wire logic [SLOT8_W-1:0] preload_i,
    output logic      [CNT_W-1:0]   sense_cnt_o,
    output logic      [CNT_W-1:0]   ref_cnt_o,
    output logic                    slot_end_o,
    output logic                    sense_ovf_o,
    output logic                    ref_ovf_o
);
    typedef struct packed {
        logic               sense_prev;
        logic               ref_prev;
        logic [CNT_W-1:0]   sense_cnt;
        logic [CNT_W-1:0]   ref_cnt;
        logic [SLOT8_W-1:0] slot8;
        logic [SLOT5_W-1:0] slot5;
        logic               slot_end;
        logic               sense_ovf;
        logic               ref_ovf;
    } cnt_state_t;

    cnt_state_t s_reg;
    cnt_state_t s_next;

    always_comb begin
        logic sense_rise;
        logic ref_rise;
        logic tick;
        sense_rise       = sense_lvl_i & ~s_reg.sense_prev;
        ref_rise         = ref_lvl_i & ~s_reg.ref_prev;
        // R9 R18
        tick             = slot_clk_sel_i ? div_tick_i : ref_rise;
        s_next           = s_reg;
        s_next.sense_prev = sense_lvl_i;
        s_next.ref_prev  = ref_lvl_i;
        s_next.slot_end  = 1'b0;
        s_next.sense_ovf = 1'b0;
        s_next.ref_ovf   = 1'b0;
        if (clear_i) begin
            // Programmable slot counter keeps its value
            s_next.sense_cnt = '0; // R5
            s_next.ref_cnt   = '0;
            s_next.slot5     = '0;
        end else if (load_i) begin
            s_next.sense_cnt = '0; // R6
            s_next.ref_cnt   = '0;
            s_next.slot5     = '0;
            s_next.slot8     = preload_i;
        end else if (run_i) begin
            if (sense_rise) begin
                // R1
                {s_next.sense_ovf, s_next.sense_cnt} = {1'b0, s_reg.sense_cnt} + 17'h00001;
            end
            if (HAS_REF_COUNTER && ref_rise) begin
                // R15
                {s_next.ref_ovf, s_next.ref_cnt} = {1'b0, s_reg.ref_cnt} + 17'h00001;
            end
            if (tick) begin
                // R7
                if (s_reg.slot8 == {SLOT8_W{1'b1}}) begin
                    s_next.slot8 = preload_i;
                    s_next.slot5 = s_reg.slot5 + 5'h01;
                    // R8
                    s_next.slot_end = (s_reg.slot5 == {SLOT5_W{1'b1}});
                end else begin
                    s_next.slot8 = s_reg.slot8 + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sense_cnt_o = s_reg.sense_cnt;
    assign ref_cnt_o   = s_reg.ref_cnt;
    assign slot_end_o  = s_reg.slot_end;
    assign sense_ovf_o = s_reg.sense_ovf;
    assign ref_ovf_o   = s_reg.ref_ovf;
endmodule
`default_nettype wire

// [src/capacitive_key_scan_counter.sv]
// How it works
// R1 - Count sense cycles in fixed reference window
// R2 - Four keys, four oscillators per module
// R3 - Raise interrupt when reference window ends
// R4 - Common select uses module 0 slot counter
// R5 - Start low clears counters, keeps preload
// R6 - Start rising edge switches all counters on; counters run only in modules with the key enable bit set
// R7 - Software-set 8-bit plus 5-bit slot
// R8 - 5-bit overflow stops oscillators and counters; oscillator enables drop only when the scan ends
// R9 - Slot clock: reference or system/4
// R10 - Oscillators run only when enables set
// R11 - Interrupt on all-enabled or module 0 overflow
// R12 - Keys map to modules in fours
// R13 - Single interrupt also clears all counters; the 8-bit slot counter keeps its value
// R14 - Sticky sense overflow flag, software clears
// R15 - Module 0 reference overflow flag, sticky
// R16 - Software starts after configuring registers
// R17 - Slot flag high until slot overflow
// R18 - Select bit 0 reference, 1 system/4
// R19 - 16-bit result as read-only bytes
// R20 - Results hold after scan stops
// R21 - Oscillator signals synchronised before use
`default_nettype none
module capacitive_key_scan_counter
    import touch_pkg::*;
(
    input  wire logic                      REF_CLK_I,
    input  wire logic                      RST_N_I,
    input  wire logic [touch_pkg::ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [touch_pkg::DATA_W-1:0] REG_WDATA_I,
    input  wire logic                      REG_WR_I,
    input  wire logic                      REG_RD_I,
    output logic      [touch_pkg::DATA_W-1:0] REG_RDATA_O,
    input  wire logic [touch_pkg::NUM_KEYS-1:0] SENSE_OSC_I,
    input  wire logic [touch_pkg::NUM_MODULES-1:0] REF_OSC_I,
    output logic      [touch_pkg::NUM_MODULES-1:0] KEY_OSC_EN_O,
    output logic      [touch_pkg::NUM_MODULES-1:0] REF_OSC_EN_O,
    output logic      [touch_pkg::NUM_KEYS-1:0] TOUCH_PIN_SEL_O,
    output logic                           TOUCH_IRQ_O
);
    import touch_pkg::*;

    typedef struct packed {
        logic                               start;
        logic                               common;
        logic                               sense_ovf;
        logic                               ref_ovf;
        logic                               load;
        scan_state_t                        st;
        logic [NUM_MODULES-1:0]             done;
        logic [NUM_MODULES-1:0][DATA_W-1:0] ctl0;
        logic [NUM_MODULES-1:0][DATA_W-1:0] ctl1;
        logic [NUM_MODULES-1:0][DATA_W-1:0] preload;
        logic [NUM_MODULES-1:0][CNT_W-1:0]  result;
        logic [CNT_W-1:0]                   ref_result;
        logic [1:0]                         div;
        logic [DATA_W-1:0]                  rdata;
        logic                               irq;
    } scan_regs_t;

    scan_regs_t s_reg;
    scan_regs_t s_next;

    logic                               rst_n;
    logic [NUM_KEYS-1:0]                sense_sync;
    logic [NUM_MODULES-1:0]             ref_sync;
    logic [NUM_MODULES-1:0]             sense_sel;
    logic [NUM_MODULES-1:0]             slot_end;
    logic [NUM_MODULES-1:0]             sense_ovf;
    logic [NUM_MODULES-1:0]             ref_ovf;
    logic [NUM_MODULES-1:0]             mod_run;
    logic [NUM_MODULES-1:0][CNT_W-1:0]  sense_cnt;
    logic [NUM_MODULES-1:0][CNT_W-1:0]  ref_cnt;
    logic                               div_tick;
    logic                               end_now;
    logic                               cnt_clear;

    function automatic logic in_module_space(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W:0] top;
        top = {1'b0, MOD_BASE_ADDR} + (ADDR_W + 1)'(NUM_MODULES << MOD_STRIDE_LOG2);
        return (addr >= MOD_BASE_ADDR) && ({1'b0, addr} < top);
    endfunction

    function automatic int module_of(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] rel;
        rel = addr - MOD_BASE_ADDR;
        return int'(rel >> MOD_STRIDE_LOG2);
    endfunction

    // Reset release through two flops
    sync2 #(
        .WIDTH (1)
    ) u_rst_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (1'b1),
        .q_o     (rst_n)
    );

    // Oscillators are asynchronous to the system clock
    sync2 #(
        .WIDTH (NUM_KEYS + NUM_MODULES)
    ) u_osc_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .d_i     ({REF_OSC_I, SENSE_OSC_I}),
        .q_o     ({ref_sync, sense_sync})
    ); // R21

    assign div_tick  = (s_reg.div == SYS_DIV_LAST);
    assign cnt_clear = ~s_reg.start | end_now;

    genvar m;
    generate
        for (m = 0; m < NUM_MODULES; m++) begin : g_mod
            // R2 R12
            assign sense_sel[m] =
                sense_sync[m*KEYS_PER_MODULE + int'(s_reg.ctl0[m][KEY_SEL_LSB +: 2])];
            // Common slot: a module's own slot end must not freeze it
            assign mod_run[m] = (s_reg.st == SCAN_RUN) & ~(s_reg.done[m] & ~s_reg.common)
                              & s_reg.ctl1[m][KEY_EN_BIT]; // R4
            // R10 R8 R16
            assign KEY_OSC_EN_O[m] = (s_reg.st == SCAN_RUN) & s_reg.ctl1[m][KEY_EN_BIT];
            assign REF_OSC_EN_O[m] = (s_reg.st == SCAN_RUN) & s_reg.ctl1[m][REF_EN_BIT];
            assign TOUCH_PIN_SEL_O[m*KEYS_PER_MODULE +: KEYS_PER_MODULE] =
                s_reg.ctl1[m][KEYS_PER_MODULE-1:0];

            key_module_counter #(
                .HAS_REF_COUNTER (m == 0)
            ) u_cnt (
                .clk_i          (REF_CLK_I),
                .rst_n_i        (rst_n),
                .run_i          (mod_run[m]),
                .clear_i        (cnt_clear),
                .load_i         (s_reg.load),
                .slot_clk_sel_i (s_reg.ctl1[m][SLOT_CLK_SEL_BIT]),
                .div_tick_i     (div_tick),
                .sense_lvl_i    (sense_sel[m]),
                .ref_lvl_i      (ref_sync[m]),
                .preload_i      (s_reg.preload[m]),
                .sense_cnt_o    (sense_cnt[m]),
                .ref_cnt_o      (ref_cnt[m]),
                .slot_end_o     (slot_end[m]),
                .sense_ovf_o    (sense_ovf[m]),
                .ref_ovf_o      (ref_ovf[m])
            );
        end
    endgenerate

    // Disabled modules never block the all-enabled end
    always_comb begin
        logic [NUM_MODULES-1:0] done_now;
        logic [NUM_MODULES-1:0] key_en;
        done_now = s_reg.done | slot_end;
        for (int i = 0; i < NUM_MODULES; i++) begin
            key_en[i] = s_reg.ctl1[i][KEY_EN_BIT];
        end
        end_now = (s_reg.st == SCAN_RUN)
                & (s_reg.common ? done_now[0] : &(done_now | ~key_en)); // R4 R11
    end

    always_comb begin
        logic             wr_ctrl;
        logic             wr_mod;
        int               wm;
        int               rm;
        logic [2:0]       wofs;
        logic [2:0]       rofs;
        logic [DATA_W-1:0] rd;
        wr_ctrl = REG_WR_I && (REG_ADDR_I == CTRL0_ADDR);
        wr_mod  = REG_WR_I && in_module_space(REG_ADDR_I);
        wm      = module_of(REG_ADDR_I);
        rm      = wm;
        wofs    = REG_ADDR_I[2:0];
        rofs    = REG_ADDR_I[2:0];
        rd      = '0;
        s_next  = s_reg;
        s_next.irq  = 1'b0;
        s_next.load = 1'b0;
        s_next.div  = s_reg.div + 2'h1;

        if (wr_ctrl) begin
            // R6 R16
            s_next.load   = REG_WDATA_I[START_BIT] & ~s_reg.start;
            s_next.start  = REG_WDATA_I[START_BIT];
            s_next.common = REG_WDATA_I[COMMON_BIT];
            // Writing 0 clears a flag, writing 1 leaves it
            if (!REG_WDATA_I[SENSE_OVF_BIT]) begin
                s_next.sense_ovf = 1'b0;
            end
            if (!REG_WDATA_I[REF_OVF_BIT]) begin
                s_next.ref_ovf = 1'b0;
            end
        end
        // Set wins over a clear in the same cycle
        if (|sense_ovf) begin
            s_next.sense_ovf = 1'b1; // R14
        end
        if (ref_ovf[0]) begin
            s_next.ref_ovf = 1'b1; // R15
        end

        if (wr_mod) begin
            case (wofs)
                MOD_CTL0_OFS: begin
                    s_next.ctl0[wm] = REG_WDATA_I;
                end
                MOD_CTL1_OFS: begin
                    // Bit 6 is not implemented
                    s_next.ctl1[wm] = REG_WDATA_I & 8'hBF;
                end
                MOD_PRELOAD_OFS: begin
                    s_next.preload[wm] = REG_WDATA_I; // R7
                end
                default: begin
                end
            endcase
        end

        if (s_reg.load) begin
            s_next.done = '0;
        end else begin
            s_next.done = s_reg.done | slot_end;
        end

        case (s_reg.st)
            SCAN_IDLE: begin
                if (s_reg.load) begin
                    s_next.st = SCAN_RUN;
                end
            end
            SCAN_RUN: begin
                if (end_now) begin
                    // Latch before the working counters are wiped
                    s_next.st         = SCAN_DONE;
                    s_next.irq        = 1'b1; // R3 R13
                    s_next.result     = sense_cnt; // R20
                    s_next.ref_result = ref_cnt[0];
                end
            end
            SCAN_DONE: begin
                s_next.st = SCAN_DONE;
            end
            default: begin
                s_next.st = SCAN_IDLE;
            end
        endcase
        if (!s_reg.start) begin
            s_next.st = SCAN_IDLE; // R5
        end

        if (REG_ADDR_I == CTRL0_ADDR) begin
            rd[START_BIT]     = s_reg.start;
            rd[COMMON_BIT]    = s_reg.common;
            rd[SENSE_OVF_BIT] = s_reg.sense_ovf;
            rd[REF_OVF_BIT]   = s_reg.ref_ovf;
            rd[SLOT_FLAG_BIT] = (s_reg.st == SCAN_RUN); // R17
        end else if (REG_ADDR_I == REF_CNT_LO_ADDR) begin
            rd = s_reg.ref_result[7:0]; // R19
        end else if (REG_ADDR_I == REF_CNT_HI_ADDR) begin
            rd = s_reg.ref_result[15:8];
        end else if (in_module_space(REG_ADDR_I)) begin
            case (rofs)
                MOD_CTL0_OFS:    rd = s_reg.ctl0[rm];
                MOD_CTL1_OFS:    rd = s_reg.ctl1[rm];
                MOD_PRELOAD_OFS: rd = s_reg.preload[rm];
                MOD_CNT_LO_OFS:  rd = s_reg.result[rm][7:0]; // R19
                MOD_CNT_HI_OFS:  rd = s_reg.result[rm][15:8];
                default:         rd = '0;
            endcase
        end
        s_next.rdata = REG_RD_I ? rd : s_reg.rdata;
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_reg            <= '0;
            s_reg.start      <= CTRL0_RST[START_BIT];
            s_reg.common     <= CTRL0_RST[COMMON_BIT];
            s_reg.st         <= SCAN_IDLE;
            s_reg.ctl0       <= {NUM_MODULES{MOD_CTL_RST}};
            s_reg.ctl1       <= {NUM_MODULES{MOD_CTL_RST}};
            s_reg.preload    <= {NUM_MODULES{PRELOAD_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign REG_RDATA_O = s_reg.rdata;
    assign TOUCH_IRQ_O = s_reg.irq;
endmodule
`default_nettype wire

// [tb/capacitive_key_scan_counter_asserts.sv]
`default_nettype none
module capacitive_key_scan_counter_asserts (
    input wire logic                                REF_CLK_I,
    input wire logic                                RST_N_I,
    input wire logic [touch_pkg::ADDR_W-1:0]        REG_ADDR_I,
    input wire logic [touch_pkg::DATA_W-1:0]        REG_WDATA_I,
    input wire logic                                REG_WR_I,
    input wire logic                                REG_RD_I,
    input wire logic [touch_pkg::DATA_W-1:0]        REG_RDATA_O,
    input wire logic [touch_pkg::NUM_MODULES-1:0]   KEY_OSC_EN_O,
    input wire logic [touch_pkg::NUM_MODULES-1:0]   REF_OSC_EN_O,
    input wire logic [touch_pkg::NUM_KEYS-1:0]      TOUCH_PIN_SEL_O,
    input wire logic                                TOUCH_IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import touch_pkg::*;
    logic start_q;
    logic key0_q;
    logic irq_seen_q;
    wire  ctl_wr = REG_WR_I && REG_ADDR_I == CTRL0_ADDR;
    wire  mapped = REG_ADDR_I < 8'h03 ||
                   (REG_ADDR_I >= 8'h10 && REG_ADDR_I < 8'h38 && REG_ADDR_I[2:0] < 3'h5);
    wire  [9:0] en_all = {KEY_OSC_EN_O, REF_OSC_EN_O};
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Shadow of what software asked for, so outputs can be judged against it
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            start_q <= 1'b0;
            key0_q <= 1'b0;
            irq_seen_q <= 1'b0;
        end else begin
            if (ctl_wr) start_q <= REG_WDATA_I[START_BIT];
            if (REG_WR_I && REG_ADDR_I == 8'h11) key0_q <= REG_WDATA_I[KEY_EN_BIT];
            if (ctl_wr && REG_WDATA_I[START_BIT] && !start_q) irq_seen_q <= 1'b0;
            else if (TOUCH_IRQ_O) irq_seen_q <= 1'b1;
        end
    end
    AST_IRQ_PULSE: assert property (TOUCH_IRQ_O |=> !TOUCH_IRQ_O)
        else $error("interrupt wider than one cycle");
    AST_IRQ_ONCE: assert property (TOUCH_IRQ_O |-> !irq_seen_q)
        else $error("second interrupt in one scan");
    AST_IRQ_STOPS: assert property (TOUCH_IRQ_O |-> en_all == 10'h000)
        else $error("oscillators still enabled at interrupt");
    AST_IRQ_STARTED: assert property (TOUCH_IRQ_O |-> start_q)
        else $error("interrupt without start");
    AST_STOP_CLEARS: assert property (!start_q [*3] |-> en_all == 10'h000)
        else $error("oscillators enabled while stopped");
    AST_START_RUNS: assert property ($rose(start_q) && key0_q |-> ##[1:3] KEY_OSC_EN_O[0])
        else $error("start did not enable key oscillator");
    AST_UNMAPPED: assert property (REG_RD_I && !mapped |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data changed without read");
    AST_PIN_SEL: assert property (REG_WR_I && REG_ADDR_I == 8'h11 |=>
        TOUCH_PIN_SEL_O[3:0] == $past(REG_WDATA_I[3:0]))
        else $error("pin select mismatch");
    cover property (TOUCH_IRQ_O);
    cover property ($fell(start_q) && en_all != 10'h000);
    cover property (REG_RD_I && !mapped);
endmodule
`default_nettype wire

// [tb/touch_pad_model.sv]
`default_nettype none
module touch_pad_model #(
    parameter int SENSE_HALF_NS = 60,
    parameter int REF_HALF_NS   = 50,
    parameter int TOUCH_NS      = 20
) (
    input  wire logic [touch_pkg::NUM_MODULES-1:0] key_en_i,
    input  wire logic [touch_pkg::NUM_MODULES-1:0] ref_en_i,
    input  wire logic [touch_pkg::NUM_KEYS-1:0]    touched_i,
    output wire logic [touch_pkg::NUM_KEYS-1:0]    sense_osc_o,
    output wire logic [touch_pkg::NUM_MODULES-1:0] ref_osc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import touch_pkg::*;
    // Each key its own oscillator; a touch adds capacitance, lowering frequency
    for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
        logic osc = 1'b0;
        assign sense_osc_o[k] = osc;
        always begin
            if (key_en_i[k / KEYS_PER_MODULE] === 1'b1) begin
                #(SENSE_HALF_NS + 5 * k + (touched_i[k] ? TOUCH_NS : 0));
                osc = ~osc & key_en_i[k / KEYS_PER_MODULE];
            end else begin
                osc = 1'b0;
                @(key_en_i[k / KEYS_PER_MODULE]);
            end
        end
    end
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_ref
        logic osc = 1'b0;
        assign ref_osc_o[m] = osc;
        always begin
            if (ref_en_i[m] === 1'b1) begin
                #(REF_HALF_NS);
                osc = ~osc & ref_en_i[m];
            end else begin
                osc = 1'b0;
                @(ref_en_i[m]);
            end
        end
    end
endmodule
`default_nettype wire

// [tb/capacitive_key_scan_counter_tb.sv]
`default_nettype none
module capacitive_key_scan_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import touch_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        irq;
    logic [19:0] sense;
    logic [19:0] pin_sel;
    logic [19:0] touched = '0;
    logic [4:0]  ref_osc;
    logic [4:0]  key_en;
    logic [4:0]  ref_en;
    int          mismatches = 0;
    int          check_count = 0;
    always #5 clk = ~clk;
    capacitive_key_scan_counter i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .SENSE_OSC_I(sense), .REF_OSC_I(ref_osc), .KEY_OSC_EN_O(key_en),
        .REF_OSC_EN_O(ref_en), .TOUCH_PIN_SEL_O(pin_sel), .TOUCH_IRQ_O(irq));
    touch_pad_model i_pads (.key_en_i(key_en), .ref_en_i(ref_en), .touched_i(touched),
        .sense_osc_o(sense), .ref_osc_o(ref_osc));
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic in_rng(string name, int v, int lo, int hi);
        check(name, 16'(v >= lo && v <= hi), 16'h0001);
    endtask
    task automatic reg_wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd16(logic [7:0] a, output int v);
        logic [7:0] lo;
        logic [7:0] hi;
        reg_rd(a, lo);
        reg_rd(a + 8'h01, hi);
        v = {hi, lo};
    endtask
    function automatic logic [7:0] mod_a(int n, int ofs);
        return MOD_BASE_ADDR + 8'(n * 8 + ofs);
    endfunction
    // Start from stopped, count edges until the interrupt, bounded
    task automatic scan(logic common, int limit, logic [4:0] en, output int cyc);
        reg_wr(CTRL0_ADDR, 8'h00);
        reg_wr(CTRL0_ADDR, {6'h00, common, 1'b1});
        cyc = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            #1 cyc++;
            if (cyc == 10) check("osc enables", {6'h0, key_en, ref_en}, {6'h0, en, en});
            if (cyc > limit) begin
                mismatches++;
                summarize();
            end
        end
        check("stopped", {6'h0, key_en, ref_en}, 16'h0000);
    endtask
    initial begin
        logic [7:0] d;
        int v;
        int cyc;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 8'h38; a++) begin
            reg_rd(8'(a), d);
            check("reset value", d, 8'h00);
        end
        reg_wr(8'h13, 8'hFF);
        reg_wr(8'h01, 8'hFF);
        reg_wr(8'h05, 8'hFF);
        reg_rd(8'h13, d);
        check("count read only", d, 8'h00);
        reg_rd(8'h01, d);
        check("ref count read only", d, 8'h00);
        reg_rd(8'h05, d);
        check("unmapped", d, 8'h00);
        for (int n = 0; n < NUM_MODULES; n++) begin
            reg_wr(mod_a(n, 1), 8'hC0 | 8'(n + 1));
            reg_rd(mod_a(n, 1), d);
            check("ctl1 readback", d, 8'h80 | 8'(n + 1));
            check("pin select", pin_sel[4*n+:4], 4'(n + 1));
        end
        $display("Test registers done");
        // Key 2, system clock slot: 16 ticks a wrap, 32 wraps, 4 clocks a tick
        reg_wr(mod_a(0, 0), 8'h80);
        reg_wr(mod_a(0, 1), 8'hBF);
        reg_wr(mod_a(0, 2), 8'hF0);
        scan(1'b0, 2200, 5'h01, cyc);
        in_rng("slot length", cyc, 2040, 2064);
        rd16(mod_a(0, 3), v);
        in_rng("sense count", v, 143, 149);
        rd16(REF_CNT_LO_ADDR, v);
        in_rng("ref count", v, 201, 207);
        repeat (40) @(posedge clk);
        rd16(REF_CNT_LO_ADDR, cyc);
        check("result held", 16'(cyc), 16'(v));
        $display("Test system clock slot done");
        touched <= 20'h00004;
        reg_wr(mod_a(0, 1), 8'h3F);
        scan(1'b0, 5300, 5'h01, cyc);
        in_rng("ref slot length", cyc, 5110, 5140);
        rd16(mod_a(0, 3), v);
        in_rng("touched count", v, 281, 287);
        rd16(REF_CNT_LO_ADDR, v);
        in_rng("ref edges", v, 509, 515);
        $display("Test reference slot done");
        touched <= 20'h00000;
        reg_wr(mod_a(0, 1), 8'hB0);
        reg_wr(mod_a(0, 2), 8'hFF);
        reg_wr(mod_a(1, 1), 8'hB0);
        reg_wr(mod_a(1, 2), 8'hF0);
        scan(1'b0, 2200, 5'h03, cyc);
        in_rng("all enabled modules", cyc, 2040, 2064);
        scan(1'b1, 2200, 5'h03, cyc);
        in_rng("common slot", cyc, 120, 140);
        reg_rd(CTRL0_ADDR, d);
        check("flag after end", d, 8'h03);
        $display("Test common slot done");
        reg_wr(CTRL0_ADDR, 8'h00);
        // Short common slot, so a missed abort would interrupt inside the window
        reg_wr(CTRL0_ADDR, 8'h03);
        reg_rd(CTRL0_ADDR, d);
        check("flag running", d, 8'h13);
        reg_wr(CTRL0_ADDR, 8'h00);
        repeat (3) @(posedge clk);
        #1 check("abort stops", {6'h0, key_en, ref_en}, 16'h0000);
        cyc = 0;
        repeat (300) begin
            @(posedge clk);
            #1 if (irq !== 1'b0) cyc++;
        end
        check("no irq after abort", 16'(cyc), 16'h0000);
        $display("Test abort done");
        summarize();
    end
endmodule
bind capacitive_key_scan_counter capacitive_key_scan_counter_asserts i_chk (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .KEY_OSC_EN_O(KEY_OSC_EN_O), .REF_OSC_EN_O(REF_OSC_EN_O),
    .TOUCH_PIN_SEL_O(TOUCH_PIN_SEL_O), .TOUCH_IRQ_O(TOUCH_IRQ_O));
`default_nettype wire
